// >>> rtl/fos_status.sv
// status word generation of the flash erase/program engine
`timescale 1ns/100ps
module fos_status #(
	parameter int WINDOW_CYCLES = fos_pkg::WINDOW_CYC,
	parameter int PROT_CYCLES   = fos_pkg::PROT_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          srst,
	input  wire logic                          pgmStart,
	input  wire logic [fos_pkg::ADDR_W-1:0]    pgmAddr,
	input  wire logic [fos_pkg::BLK_W-1:0]     pgmBlk,
	input  wire logic [fos_pkg::DATA_W-1:0]    pgmData,
	input  wire logic [fos_pkg::DATA_W-1:0]    pgmOldData,
	input  wire logic                          eraseConfirm,
	input  wire logic [fos_pkg::BLK_W-1:0]     eraseBlk,
	input  wire logic                          eraseProtected,
	input  wire logic                          chipErase,
	input  wire logic                          suspendCmd,
	input  wire logic                          resumeCmd,
	input  wire logic                          readResetCmd,
	input  wire logic                          engDone,
	input  wire logic                          engFail,
	input  wire logic                          rdStrobe,
	input  wire logic [fos_pkg::ADDR_W-1:0]    rdAddr,
	input  wire logic [fos_pkg::BLK_W-1:0]     rdBlk,
	input  wire logic [fos_pkg::DATA_W-1:0]    arrayData,
	output logic [fos_pkg::DATA_W-1:0]         rdData,
	output logic                               rdValid,
	output logic                               rdIsStatus,
	output logic                               eraseGo,
	output logic [fos_pkg::NUM_BLK-1:0]        eraseMask,
	output logic                               engineBusy
);
	typedef struct packed {
		fos_pkg::fos_state_t                st;
		logic [fos_pkg::ADDR_W-1:0]         pAddr;
		logic [fos_pkg::BLK_W-1:0]          pBlk;
		logic                               pBit7;
		logic [fos_pkg::NUM_BLK-1:0]        eMask;
		logic                               errErase;
		logic                               readTgl;
		logic                               suspTgl;
		logic                               fail;
		logic [fos_pkg::DATA_W-1:0]         rData;
		logic                               rValid;
		logic                               rStat;
	} fos_state_s_t;

	localparam logic [fos_pkg::CNT_W-1:0] WIN_LOAD = fos_pkg::CNT_W'(WINDOW_CYCLES);
	localparam logic [fos_pkg::CNT_W-1:0] PROT_LOAD = fos_pkg::CNT_W'(PROT_CYCLES);
	localparam logic [fos_pkg::BLK_W-1:0] BLK_LAST = fos_pkg::BLK_W'(fos_pkg::NUM_BLK - 1);

	fos_state_s_t s_q;
	fos_state_s_t s_d;
	fos_tmr_if    tif ();

	logic                        rdInErase;
	logic                        rdAtPgm;
	logic                        useStatus;
	logic                        dataPoll;
	logic                        readToggle;
	logic                        failBit;
	logic                        eraseWindow;
	logic                        suspToggle;
	logic                        flipRead;
	logic                        flipSusp;
	logic                        pgmBad;
	logic                        failSet;
	logic                        rdBlkOk;
	logic                        pgmInErase;
	logic [fos_pkg::NUM_BLK-1:0] blkBit;
	logic [fos_pkg::DATA_W-1:0]  statusWord;

	fos_timer u_timer (
		.clk  (clk),
		.srst (srst),
		.tif  (tif)
	);

	assign blkBit = fos_pkg::BLK_ONE << eraseBlk;
	// a block index beyond the last block never matches the erase mask
	assign rdBlkOk = (rdBlk <= BLK_LAST);
	assign rdInErase = rdBlkOk && s_q.eMask[rdBlk];
	assign pgmInErase = (pgmBlk <= BLK_LAST) && s_q.eMask[pgmBlk];
	assign rdAtPgm = (rdAddr == s_q.pAddr);
	assign pgmBad = |(pgmData & ~pgmOldData);

	// which reads see the status word instead of array data
	always_comb begin
		case (s_q.st)
			fos_pkg::ST_READ: useStatus = 1'b0;
			fos_pkg::ST_SUSP: useStatus = rdInErase;
			fos_pkg::ST_SUSP_PROG: useStatus = rdInErase | rdAtPgm;
			default: useStatus = 1'b1;
		endcase
	end

	// status bit values seen by the current read
	always_comb begin
		dataPoll = 1'b1;
		readToggle = s_q.readTgl;
		failBit = s_q.fail;
		eraseWindow = 1'b1;
		suspToggle = s_q.suspTgl;
		case (s_q.st)
			fos_pkg::ST_PROG: dataPoll = ~s_q.pBit7;
			fos_pkg::ST_SUSP_PROG: begin
				dataPoll = ~s_q.pBit7;
				if (rdAtPgm) begin
					suspToggle = 1'b1;
				end
				if (rdInErase) begin
					readToggle = 1'b1;
				end
			end
			fos_pkg::ST_WINDOW: begin
				dataPoll = 1'b0;
				eraseWindow = 1'b0;
			end
			fos_pkg::ST_ERASE: dataPoll = 1'b0;
			fos_pkg::ST_PROT: dataPoll = 1'b0;
			fos_pkg::ST_SUSP: begin
				dataPoll = 1'b1;
				readToggle = 1'b1;
			end
			fos_pkg::ST_ERROR: dataPoll = s_q.errErase ? 1'b0 : ~s_q.pBit7;
			default: dataPoll = 1'b1;
		endcase
	end

	always_comb begin
		statusWord = fos_pkg::STATUS_ZERO;
		statusWord[fos_pkg::POLL_POS] = dataPoll;
		statusWord[fos_pkg::RTGL_POS] = readToggle;
		statusWord[fos_pkg::FAIL_POS] = failBit;
		statusWord[fos_pkg::EWIN_POS] = eraseWindow;
		statusWord[fos_pkg::STGL_POS] = suspToggle;
	end

	// which status reads invert the toggle flops
	always_comb begin
		flipRead = 1'b0;
		flipSusp = 1'b0;
		if (rdStrobe) begin
			case (s_q.st)
				fos_pkg::ST_PROG: flipRead = 1'b1;
				fos_pkg::ST_WINDOW, fos_pkg::ST_ERASE: begin
					flipRead = 1'b1;
					flipSusp = 1'b1;
				end
				fos_pkg::ST_SUSP: flipSusp = rdInErase;
				fos_pkg::ST_SUSP_PROG: begin
					flipRead = rdAtPgm & ~rdInErase;
					flipSusp = rdInErase;
				end
				fos_pkg::ST_ERROR: begin
					flipRead = ~s_q.errErase;
					flipSusp = s_q.errErase & rdInErase;
				end
				default: begin
					flipRead = 1'b0;
					flipSusp = 1'b0;
				end
			endcase
		end
	end

	// command and engine event sequencing
	always_comb begin
		s_d = s_q;
		failSet = 1'b0;
		tif.start = 1'b0;
		tif.stop = 1'b0;
		tif.load = WIN_LOAD;
		eraseGo = 1'b0;
		if (flipRead) begin
			s_d.readTgl = ~s_q.readTgl;
		end
		if (flipSusp) begin
			s_d.suspTgl = ~s_q.suspTgl;
		end
		s_d.rValid = rdStrobe;
		s_d.rStat = rdStrobe & useStatus;
		if (rdStrobe) begin
			s_d.rData = useStatus ? statusWord : arrayData;
		end
		case (s_q.st)
			fos_pkg::ST_READ: begin
				if (pgmStart) begin
					s_d.pAddr = pgmAddr;
					s_d.pBlk = pgmBlk;
					s_d.pBit7 = pgmData[fos_pkg::POLL_POS];
					s_d.fail = pgmBad;
					failSet = pgmBad;
					s_d.st = pgmBad ? fos_pkg::ST_ERROR : fos_pkg::ST_PROG;
				end else if (eraseConfirm && eraseProtected) begin
					tif.start = 1'b1;
					tif.load = PROT_LOAD;
					s_d.st = fos_pkg::ST_PROT;
				end else if (eraseConfirm || chipErase) begin
					s_d.eMask = chipErase ? {fos_pkg::NUM_BLK{1'b1}} : blkBit;
					s_d.errErase = 1'b1;
					if (chipErase) begin
						s_d.st = fos_pkg::ST_ERASE;
						eraseGo = 1'b1;
					end else begin
						tif.start = 1'b1;
						s_d.st = fos_pkg::ST_WINDOW;
					end
				end
			end
			fos_pkg::ST_WINDOW: begin
				if (suspendCmd) begin
					tif.stop = 1'b1;
					s_d.readTgl = ~s_q.readTgl;
					s_d.st = fos_pkg::ST_SUSP;
				end else if (eraseConfirm && !eraseProtected) begin
					tif.start = 1'b1;
					s_d.eMask = s_q.eMask | blkBit;
				end else if (tif.expired) begin
					eraseGo = 1'b1;
					s_d.st = fos_pkg::ST_ERASE;
				end
			end
			fos_pkg::ST_ERASE: begin
				if (engFail) begin
					s_d.fail = 1'b1;
					failSet = 1'b1;
					s_d.st = fos_pkg::ST_ERROR;
				end else if (engDone) begin
					s_d.st = fos_pkg::ST_READ;
				end else if (suspendCmd) begin
					s_d.readTgl = ~s_q.readTgl;
					s_d.st = fos_pkg::ST_SUSP;
				end
			end
			fos_pkg::ST_SUSP: begin
				if (resumeCmd) begin
					s_d.readTgl = ~s_q.readTgl;
					s_d.st = fos_pkg::ST_ERASE;
				end else if (pgmStart) begin
					s_d.pAddr = pgmAddr;
					s_d.pBlk = pgmBlk;
					s_d.pBit7 = pgmData[fos_pkg::POLL_POS];
					if (pgmInErase) begin
						s_d.suspTgl = ~s_d.suspTgl;
					end
					s_d.st = fos_pkg::ST_SUSP_PROG;
				end
			end
			fos_pkg::ST_SUSP_PROG: begin
				if (engDone || engFail) begin
					s_d.fail = engFail;
					failSet = engFail;
					s_d.st = fos_pkg::ST_SUSP;
				end
			end
			fos_pkg::ST_PROG: begin
				if (engFail) begin
					s_d.fail = 1'b1;
					failSet = 1'b1;
					s_d.st = fos_pkg::ST_ERROR;
				end else if (engDone) begin
					s_d.st = fos_pkg::ST_READ;
				end
			end
			fos_pkg::ST_PROT: begin
				if (tif.expired) begin
					s_d.st = fos_pkg::ST_READ;
				end
			end
			fos_pkg::ST_ERROR: begin
				s_d.st = fos_pkg::ST_ERROR;
			end
			default: s_d.st = fos_pkg::ST_READ;
		endcase
		// a failure reported in the same cycle outranks the clear
		if (readResetCmd && s_q.st != fos_pkg::ST_SUSP_PROG && !failSet) begin
			tif.stop = 1'b1;
			s_d.fail = 1'b0;
			s_d.st = fos_pkg::ST_READ;
		end
		if (s_d.st == fos_pkg::ST_READ) begin
			s_d.readTgl = 1'b0;
			s_d.suspTgl = 1'b0;
			s_d.eMask = fos_pkg::BLK_NONE;
			s_d.errErase = 1'b0;
		end
		if (s_d.st == fos_pkg::ST_PROG ||
			(s_d.st == fos_pkg::ST_ERROR && s_q.st == fos_pkg::ST_READ)) begin
			s_d.errErase = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '{
				st: fos_pkg::ST_READ,
				pAddr: '0,
				pBlk: '0,
				pBit7: 1'b0,
				eMask: fos_pkg::BLK_NONE,
				errErase: 1'b0,
				readTgl: 1'b0,
				suspTgl: 1'b0,
				fail: 1'b0,
				rData: fos_pkg::STATUS_ZERO,
				rValid: 1'b0,
				rStat: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdData = s_q.rData;
	assign rdValid = s_q.rValid;
	assign rdIsStatus = s_q.rStat;
	assign eraseMask = s_q.eMask;
	assign engineBusy = (s_q.st != fos_pkg::ST_READ);
endmodule

// >>> shared/fos_pkg.sv
// shared constants and types of the flash operation status block
package fos_pkg;
	localparam int CLK_MHZ = 100;
	localparam int WINDOW_US = 96;
	localparam int PROT_US = 100;
	localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
	localparam int PROT_CYC = PROT_US * CLK_MHZ;
	localparam int CNT_W = 14;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 18;
	localparam int NUM_BLK = 11;
	localparam int BLK_W = 4;
	localparam int POLL_POS = 7;
	localparam int RTGL_POS = 6;
	localparam int FAIL_POS = 5;
	localparam int EWIN_POS = 3;
	localparam int STGL_POS = 2;
	localparam logic [DATA_W-1:0] STATUS_ZERO = 16'h0000;
	localparam logic [NUM_BLK-1:0] BLK_NONE = 11'h000;
	localparam logic [NUM_BLK-1:0] BLK_ONE = 11'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

	typedef enum logic [2:0] {
		ST_READ,
		ST_WINDOW,
		ST_ERASE,
		ST_PROG,
		ST_SUSP,
		ST_SUSP_PROG,
		ST_PROT,
		ST_ERROR
	} fos_state_t;
endpackage

// >>> shared/fos_tmr_if.sv
// link between the status logic and its interval timer
`timescale 1ns/100ps
interface fos_tmr_if;
	logic                          start;
	logic                          stop;
	logic [fos_pkg::CNT_W-1:0]     load;
	logic                          expired;

	modport ctl (output start, output stop, output load, input expired);
	modport tmr (input start, input stop, input load, output expired);
endinterface

// >>> rtl/fos_timer.sv
// one-shot down counter for the erase window and protected-erase hold
`timescale 1ns/100ps
module fos_timer (
	input  wire logic  clk,
	input  wire logic  srst,
	fos_tmr_if.tmr     tif
);
	typedef struct packed {
		logic [fos_pkg::CNT_W-1:0] cnt;
		logic                      run;
		logic                      expired;
	} fos_tmr_state_t;

	fos_tmr_state_t s_q;
	fos_tmr_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.expired = 1'b0;
		if (tif.start) begin
			s_d.cnt = tif.load;
			s_d.run = 1'b1;
		end else if (tif.stop) begin
			s_d.run = 1'b0;
		end else if (s_q.run) begin
			if (s_q.cnt <= fos_pkg::CNT_ONE) begin
				s_d.run = 1'b0;
				s_d.expired = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - fos_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '{cnt: fos_pkg::CNT_ZERO, run: 1'b0, expired: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tif.expired = s_q.expired;
endmodule

// >>> bench/fos_host_model.sv
// host read master facing the flash status block
`timescale 1ns/100ps
module fos_host_model (
	input  logic        clk,
	output logic        rdStrobe,
	output logic [17:0] rdAddr,
	output logic [3:0]  rdBlk,
	output logic [15:0] arrayData,
	input  logic [15:0] rdData,
	input  logic        rdValid,
	input  logic        rdIsStatus
);
	logic [15:0] dat;
	logic        vld;
	logic        sts;
	initial begin
		rdStrobe = 1'b0;
		rdAddr = 18'h00000;
		rdBlk = 4'h0;
		arrayData = 16'h0000;
	end
	// one read, held over one edge; lines inverted once released
	task automatic rd(logic [17:0] a, logic [3:0] b, logic [15:0] d);
		@(negedge clk);
		rdStrobe = 1'b1;
		rdAddr = a;
		rdBlk = b;
		arrayData = d;
		@(negedge clk);
		rdStrobe = 1'b0;
		vld = rdValid;
		sts = rdIsStatus;
		dat = sts ? rdData & 16'h00EC : rdData;
		rdAddr = ~a;
		rdBlk = ~b;
		arrayData = ~d;
	endtask
endmodule

// >>> bench/fos_status_asserts.sv
// port checks of the flash status block
`timescale 1ns/100ps
module fos_status_asserts (
	input logic        clk,
	input logic        srst,
	input logic        pgmStart,
	input logic [15:0] pgmData,
	input logic [15:0] pgmOldData,
	input logic        eraseConfirm,
	input logic        eraseProtected,
	input logic        chipErase,
	input logic        suspendCmd,
	input logic        resumeCmd,
	input logic        readResetCmd,
	input logic        engDone,
	input logic        engFail,
	input logic        rdStrobe,
	input logic [15:0] arrayData,
	input logic [15:0] rdData,
	input logic        rdValid,
	input logic        rdIsStatus,
	input logic        engineBusy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic q;
	logic bad;
	logic okp;
	logic d7;
	logic r6;
	assign q = !(pgmStart | eraseConfirm | chipErase | suspendCmd | resumeCmd
		| readResetCmd | engDone | engFail);
	assign bad = |(pgmData & ~pgmOldData);
	assign okp = !engineBusy && !bad;
	assign d7 = pgmData[7];
	assign r6 = rdData[6];
	a_read_latency: assert property (rdStrobe |=> rdValid)
		else $error("read answer missing");
	a_idle_array: assert property (rdStrobe && !engineBusy |=>
		!rdIsStatus && rdData == $past(arrayData)) else $error("idle read wrong");
	a_rsvd_zero: assert property (rdValid && rdIsStatus |->
		(rdData & 16'hFF13) == 16'h0000) else $error("reserved bits set");
	a_poll_prog: assert property (pgmStart && okp ##1 q ##1 (q && rdStrobe) |=>
		rdIsStatus && rdData[7] == !$past(d7, 3)) else $error("poll bit wrong");
	a_toggle_prog: assert property (pgmStart && okp ##1 q ##1 (q && rdStrobe)
		##1 q ##1 (q && rdStrobe) |=> r6 != $past(r6, 2)) else $error("no toggle");
	a_bad_prog: assert property (pgmStart && !engineBusy && bad ##1 q
		##1 (q && rdStrobe) |=> rdData[5]) else $error("failure bit low");
	a_erase_poll: assert property (chipErase && !engineBusy ##1 q
		##1 (q && rdStrobe) |=> rdIsStatus && !rdData[7]) else $error("erase poll");
	a_window_low: assert property (eraseConfirm && !engineBusy && !eraseProtected
		##1 q ##1 (q && rdStrobe) |=> !rdData[3]) else $error("window bit high");
	a_fail_clear: assert property (engFail ##1 q[*3] ##1 readResetCmd |=>
		!engineBusy) else $error("read/reset ignored");
endmodule
bind fos_status fos_status_asserts chk (.clk, .srst, .pgmStart, .pgmData,
	.pgmOldData, .eraseConfirm, .eraseProtected, .chipErase, .suspendCmd, .resumeCmd,
	.readResetCmd, .engDone, .engFail, .rdStrobe, .arrayData, .rdData, .rdValid,
	.rdIsStatus, .engineBusy);

// >>> bench/flash_operation_status_tb.sv
// self-checking bench of the flash status block
`timescale 1ns/100ps
module flash_operation_status_tb;
	logic        clk = 0;
	logic        srst = 1;
	logic [7:0]  cmd = 0;
	logic [17:0] pa = 0;
	logic [15:0] pd = 0;
	logic [15:0] po = 16'hFFFF;
	logic [3:0]  eb = 0;
	logic        ep = 0;
	logic        rdStrobe, rdValid, rdIsStatus, eraseGo, engineBusy;
	logic [17:0] rdAddr;
	logic [3:0]  rdBlk;
	logic [15:0] arrayData, rdData;
	logic [10:0] eraseMask;
	int          bad_count = 0;
	int          cmp_count = 0;
	integer      seed = 32'h263E;
	int          i;
	logic        t6, t2;
	always #5 clk = ~clk;
	fos_status #(.WINDOW_CYCLES(20), .PROT_CYCLES(25)) dut (.clk, .srst,
		.pgmStart(cmd[7]), .pgmAddr(pa), .pgmBlk(eb), .pgmData(pd), .pgmOldData(po),
		.eraseConfirm(cmd[6]), .eraseBlk(eb), .eraseProtected(ep), .chipErase(cmd[5]),
		.suspendCmd(cmd[4]), .resumeCmd(cmd[3]), .readResetCmd(cmd[2]),
		.engDone(cmd[1]), .engFail(cmd[0]), .rdStrobe, .rdAddr, .rdBlk, .arrayData,
		.rdData, .rdValid, .rdIsStatus, .eraseGo, .eraseMask, .engineBusy);
	fos_host_model hm (.clk, .rdStrobe, .rdAddr, .rdBlk, .arrayData, .rdData,
		.rdValid, .rdIsStatus);
	function automatic logic [15:0] sw(logic p, t, f, w, u);
		return {8'h00, p, t, f, 1'b0, w, u, 2'b00};
	endfunction
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (e !== g) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task automatic pulse(int k);
		@(negedge clk);
		cmd[k] = 1'b1;
		@(negedge clk);
		cmd = 8'h00;
	endtask
	// read and compare under mask m; s says a status word is expected
	task automatic rdk(logic [17:0] a, logic [3:0] b, logic s, logic [15:0] e, m);
		logic [15:0] r;
		r = 16'($random(seed));
		hm.rd(a, b, r);
		chk("valid", 16'h0001, {15'h0000, hm.vld});
		chk("kind", {15'h0000, s}, {15'h0000, hm.sts});
		chk("data", (s ? e : r) & m, hm.dat & m);
	endtask
	task automatic srd(logic p, logic [15:0] m);
		rdk(pa, eb, 1'b1, sw(p, t6, 1'b0, 1'b1, t2), m);
		t6 = ~t6;
		t2 = ~t2;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		srst = 0;
		pa = 18'($random(seed));
		rdk(pa, 4'h1, 1'b0, 16'h0000, 16'hFFFF);
		$display("test idle read done");
		pd = 16'($random(seed));
		eb = 4'h2;
		pulse(7);
		chk("busy", 16'h0001, {15'h0000, engineBusy});
		t6 = 0;
		t2 = 0;
		srd(~pd[7], 16'hFFF3);
		srd(~pd[7], 16'hFFF3);
		pulse(1);
		rdk(pa, eb, 1'b0, 16'h0000, 16'hFFFF);
		$display("test program done");
		po = 16'h0000;
		pd = 16'($random(seed)) | 16'h0001;
		pulse(7);
		rdk(pa, eb, 1'b1, 16'h0020, 16'h0020);
		pulse(2);
		rdk(pa, eb, 1'b0, 16'h0000, 16'hFFFF);
		po = 16'hFFFF;
		$display("test bad program done");
		eb = 4'h3;
		pulse(6);
		chk("mask", 16'h0008, {5'h00, eraseMask});
		rdk(pa, eb, 1'b1, 16'h0000, 16'h0008);
		eb = 4'h4;
		pulse(6);
		chk("mask", 16'h0018, {5'h00, eraseMask});
		for (i = 0; i < 40 && eraseGo !== 1'b1; i++)
			@(negedge clk);
		chk("erase start", 16'h0001, {15'h0000, eraseGo});
		t6 = 1;
		t2 = 1;
		srd(1'b0, 16'hFFFF);
		srd(1'b0, 16'hFFFF);
		pulse(4);
		rdk(pa, eb, 1'b1, sw(1'b1, 1'b1, 1'b0, 1'b1, t2), 16'hFFF7);
		rdk(pa, 4'h5, 1'b0, 16'h0000, 16'hFFFF);
		eb = 4'h5;
		pa = pa ^ 18'h10000;
		pulse(7);
		rdk(pa, eb, 1'b1, sw(~pd[7], 1'b0, 1'b0, 1'b0, 1'b1), 16'hFFB7);
		pulse(1);
		eb = 4'h3;
		pulse(3);
		rdk(pa, eb, 1'b1, 16'h0008, 16'hFFBB);
		pulse(1);
		rdk(pa, eb, 1'b0, 16'h0000, 16'hFFFF);
		$display("test erase suspend done");
		eb = 4'h7;
		ep = 1;
		pulse(6);
		ep = 0;
		rdk(pa, eb, 1'b1, 16'h0000, 16'h0080);
		repeat (40) @(negedge clk);
		rdk(pa, eb, 1'b0, 16'h0000, 16'hFFFF);
		$display("test protected erase done");
		pulse(5);
		rdk(pa, eb, 1'b1, 16'h0000, 16'h0080);
		pulse(0);
		rdk(pa, eb, 1'b1, 16'h0024, 16'h0024);
		rdk(pa, eb, 1'b1, 16'h0020, 16'h0024);
		pulse(2);
		rdk(pa, eb, 1'b0, 16'h0000, 16'hFFFF);
		$display("test erase failure done");
		conclude();
	end
endmodule
